/* File: hw/dimw_cfg.svh */
`ifndef DIMW_CFG_SVH
`define DIMW_CFG_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define DIMW_IDX_WDOG_MASK  10'h20B
`define DIMW_IDX_LOOP_MASK  10'h20C
`define DIMW_IDX_LIM_MASK   10'h20D
`define DIMW_IDX_REF_MASK   10'h20E
`define DIMW_IDX_RSVD_MASK  10'h20F
`define DIMW_IDX_PERIOD_LO  10'h210
`define DIMW_IDX_PERIOD_HI  10'h211
`define DIMW_IDX_STATUS     10'h212

// ****************************************
// field positions and writable bits
// ****************************************
`define DIMW_WDOG_MASK_BIT  2
`define DIMW_STAT_RUN_BIT   0
`define DIMW_STAT_EXP_BIT   1
`define DIMW_WDOG_WMASK     8'h04
`define DIMW_LOOP_WMASK     8'hFF
`define DIMW_LIM_WMASK      8'h1F
`define DIMW_REF_WMASK      8'h77

// ****************************************
// reset values
// ****************************************
`define DIMW_MASK_RST       8'h00
`define DIMW_PERIOD_RST     16'h0000

// ****************************************
// timing
// ****************************************
`define DIMW_CLK_NS         20
`define DIMW_MS_NS          1000000
`define DIMW_MS_CYCLES      (`DIMW_MS_NS / `DIMW_CLK_NS)

// ****************************************
// bus encodings
// ****************************************
`define DIMW_HSIZE_WORD     3'h2
`define DIMW_HRESP_OKAY     1'h0

`endif

/* File: hw/dimw_pkg.sv */
package dimw_pkg;

    // ****************************************
    // event carriers, laid out as the mask bytes
    // ****************************************
    typedef struct packed {
        logic switching;
        logic closed_loop;
        logic free_run;
        logic holdover;
        logic freq_unlocked;
        logic freq_locked;
        logic phase_unlocked;
        logic phase_locked;
    } dimw_loop_ev_s;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       history_updated;
        logic       freq_unclamped;
        logic       freq_clamped;
        logic       slew_unlimited;
        logic       slew_limited;
    } dimw_lim_ev_s;

    typedef struct packed {
        logic rsvd_b;
        logic ref_b_validated;
        logic ref_b_fault_cleared;
        logic ref_b_faulted;
        logic rsvd_a;
        logic ref_a_validated;
        logic ref_a_fault_cleared;
        logic ref_a_faulted;
    } dimw_ref_ev_s;

    // ****************************************
    // watchdog state
    // ****************************************
    typedef enum logic [1:0] {
        DIMW_WD_IDLE = 2'b01,
        DIMW_WD_RUN  = 2'b10
    } dimw_wd_e;

    // ****************************************
    // complete state of the block
    // ****************************************
    typedef struct packed {
        logic          ap_valid;
        logic          ap_write;
        logic [9:0]    ap_idx;
        logic [31:0]   hrdata;
        logic          hreadyout;
        logic          hresp;
        logic [7:0]    wdog_mask;
        logic [7:0]    loop_mask;
        logic [7:0]    lim_mask;
        logic [7:0]    ref_mask;
        logic [15:0]   period;
        dimw_wd_e      wd_state;
        logic [15:0]   pre;
        logic [15:0]   ms;
        logic          wd_expired;
        dimw_loop_ev_s loop_irq;
        dimw_lim_ev_s  lim_irq;
        dimw_ref_ev_s  ref_irq;
        logic          wdog_irq;
    } dimw_state_s;

endpackage

/* File: hw/dimw_top.sv */
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dimw_cfg.svh"

// Operation
// [RULE_01] mask 0x020C bit 7 passes reference-switching event of the loop controller
// [RULE_02] mask bit 6 passes entry into closed-loop operation
// [RULE_03] mask bit 5 passes entry into free run
// [RULE_04] mask bit 4 passes entry into holdover
// [RULE_05] mask bit 3 passes loss of frequency lock
// [RULE_06] mask bit 2 passes acquisition of frequency lock
// [RULE_07] mask bit 1 passes loss of phase lock
// [RULE_08] mask bit 0 passes acquisition of phase lock
// [RULE_09] 0x020D bit 4 passes history update; bits 7 to 5 reserved
// [RULE_10] 0x020D bit 3 passes frequency limiter clamped to unclamped
// [RULE_11] 0x020D bit 2 passes frequency limiter unclamped to clamped
// [RULE_12] 0x020D bit 1 passes slew limiter stopping limiting
// [RULE_13] 0x020D bit 0 passes slew limiter starting limiting
// [RULE_14] 0x020E bits 6,5,4 pass input b validated, fault cleared, faulted
// [RULE_15] 0x020E bits 2,1,0 pass input a validated, fault cleared, faulted
// [RULE_16] 16-bit watchdog period at 0x0210 low, 0x0211 high, in milliseconds
// [RULE_17] period resets to zero; zero keeps the watchdog disabled
// [RULE_18] register 0x020F is wholly reserved, no enables
// [RULE_19] each mask bit gates its event one-to-one; reset clears all masks
// [RULE_20] watchdog expiry passes when bit 2 of 0x020B is set
// [RULE_21] count milliseconds while period nonzero; rewrite restarts the count

module dimw_top
    import dimw_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `DIMW_MS_CYCLES
) (
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    // raw events from the loop controller and monitors
    input  wire dimw_loop_ev_s loop_ev,
    input  wire dimw_lim_ev_s  lim_ev,
    input  wire dimw_ref_ev_s  ref_ev,
    // masked events toward the interrupt monitor
    output dimw_loop_ev_s      loop_irq,
    output dimw_lim_ev_s       lim_irq,
    output dimw_ref_ev_s       ref_irq,
    output logic               wdog_irq,
    // watchdog state
    output logic               wdog_running
);

    // ****************************************
    // parameter checks
    // ****************************************
    if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin : g_bad_ms
        $error("MS_CYCLES must lie in 1..65536");
    end

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    // ****************************************
    // register read decode
    // ****************************************
    function automatic logic [31:0] reg_value(
        input dimw_state_s s,
        input logic [9:0]  idx
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (idx)
            `DIMW_IDX_WDOG_MASK: v[7:0] = s.wdog_mask;
            `DIMW_IDX_LOOP_MASK: v[7:0] = s.loop_mask;
            `DIMW_IDX_LIM_MASK:  v[7:0] = s.lim_mask;
            `DIMW_IDX_REF_MASK:  v[7:0] = s.ref_mask;
            `DIMW_IDX_PERIOD_LO: v[7:0] = s.period[7:0];
            `DIMW_IDX_PERIOD_HI: v[7:0] = s.period[15:8];
            `DIMW_IDX_STATUS: begin
                v[`DIMW_STAT_RUN_BIT] = (s.wd_state == DIMW_WD_RUN);
                v[`DIMW_STAT_EXP_BIT] = s.wd_expired;
            end
            // reserved mask byte and unmapped words read zero
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // ****************************************
    // state
    // ****************************************
    dimw_state_s r;
    dimw_state_s next_r;

    logic        wr_now;
    logic        wd_restart;
    logic        wd_expire;
    logic [15:0] ms_inc;

    always_comb begin
        next_r     = r;
        wr_now     = r.ap_valid && r.ap_write;
        wd_restart = 1'b0;
        wd_expire  = 1'b0;
        ms_inc     = r.ms + 16'h0001;

        // ****************************************
        // event gating
        // ****************************************
        // [RULE_01] [RULE_02] [RULE_03] [RULE_04] loop state events
        // [RULE_05] [RULE_06] [RULE_07] [RULE_08] lock events
        // [RULE_19] one-to-one gating
        next_r.loop_irq = dimw_loop_ev_s'(loop_ev & r.loop_mask);
        // [RULE_09] [RULE_10] [RULE_11] history and clamp events
        // [RULE_12] [RULE_13] slew limiter events
        next_r.lim_irq  = dimw_lim_ev_s'(lim_ev & r.lim_mask);
        // [RULE_14] [RULE_15] reference input events
        next_r.ref_irq  = dimw_ref_ev_s'(ref_ev & r.ref_mask);

        // ****************************************
        // data phase: register writes
        // ****************************************
        if (wr_now) begin
            unique case (r.ap_idx)
                `DIMW_IDX_WDOG_MASK: begin
                    next_r.wdog_mask = hwdata[7:0] & `DIMW_WDOG_WMASK;
                end
                `DIMW_IDX_LOOP_MASK: begin
                    next_r.loop_mask = hwdata[7:0] & `DIMW_LOOP_WMASK;
                end
                // [RULE_09] reserved bits stay zero
                `DIMW_IDX_LIM_MASK: begin
                    next_r.lim_mask = hwdata[7:0] & `DIMW_LIM_WMASK;
                end
                // [RULE_14] [RULE_15] reserved bits 7 and 3 stay zero
                `DIMW_IDX_REF_MASK: begin
                    next_r.ref_mask = hwdata[7:0] & `DIMW_REF_WMASK;
                end
                // [RULE_16] period low byte
                `DIMW_IDX_PERIOD_LO: begin
                    next_r.period[7:0] = hwdata[7:0];
                    wd_restart         = 1'b1;
                end
                // [RULE_16] period high byte
                `DIMW_IDX_PERIOD_HI: begin
                    next_r.period[15:8] = hwdata[7:0];
                    wd_restart          = 1'b1;
                end
                `DIMW_IDX_STATUS: begin
                    if (hwdata[`DIMW_STAT_EXP_BIT]) begin
                        next_r.wd_expired = 1'b0;
                    end
                end
                // [RULE_18] reserved mask byte ignores writes
                default: begin
                end
            endcase
        end

        // ****************************************
        // watchdog
        // ****************************************
        // [RULE_21] rewrite restarts the count from zero
        if (wd_restart) begin
            next_r.pre = 16'h0000;
            next_r.ms  = 16'h0000;
        end
        // [RULE_17] zero period keeps the watchdog idle
        if (next_r.period == 16'h0000) begin
            next_r.wd_state = DIMW_WD_IDLE;
            next_r.pre      = 16'h0000;
            next_r.ms       = 16'h0000;
        end else if (!wd_restart) begin
            unique case (r.wd_state)
                DIMW_WD_IDLE: begin
                    next_r.wd_state = DIMW_WD_RUN;
                end
                // [RULE_21] millisecond tick and period compare
                DIMW_WD_RUN: begin
                    if (r.pre == MS_LAST) begin
                        next_r.pre = 16'h0000;
                        if (ms_inc == r.period) begin
                            next_r.ms = 16'h0000;
                            wd_expire = 1'b1;
                        end else begin
                            next_r.ms = ms_inc;
                        end
                    end else begin
                        next_r.pre = r.pre + 16'h0001;
                    end
                end
                default: begin
                    next_r.wd_state = DIMW_WD_IDLE;
                end
            endcase
        end else begin
            next_r.wd_state = DIMW_WD_RUN;
        end

        // expiry set wins over a same-cycle clear
        if (wd_expire) begin
            next_r.wd_expired = 1'b1;
        end
        // [RULE_20] expiry gated by its mask bit
        next_r.wdog_irq = wd_expire && r.wdog_mask[`DIMW_WDOG_MASK_BIT];

        // ****************************************
        // address phase
        // ****************************************
        next_r.hreadyout = 1'b1;
        next_r.hresp     = `DIMW_HRESP_OKAY;
        next_r.ap_valid  = 1'b0;
        next_r.ap_write  = 1'b0;
        next_r.hrdata    = 32'h0000_0000;
        if (hsel && hready && htrans[1]) begin
            if (haddr[1:0] == 2'b00 && hsize == `DIMW_HSIZE_WORD
                && haddr[31:12] == 20'h00000) begin
                next_r.ap_valid = 1'b1;
                next_r.ap_write = hwrite;
                next_r.ap_idx   = haddr[11:2];
                if (!hwrite) begin
                    // reads see a write finishing in this cycle
                    next_r.hrdata = reg_value(next_r, haddr[11:2]);
                end
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.ap_valid   <= 1'b0;
            r.ap_write   <= 1'b0;
            r.ap_idx     <= 10'h000;
            r.hrdata     <= 32'h0000_0000;
            r.hreadyout  <= 1'b1;
            r.hresp      <= `DIMW_HRESP_OKAY;
            // [RULE_19] all masks clear at reset
            r.wdog_mask  <= `DIMW_MASK_RST;
            r.loop_mask  <= `DIMW_MASK_RST;
            r.lim_mask   <= `DIMW_MASK_RST;
            r.ref_mask   <= `DIMW_MASK_RST;
            // [RULE_17] period resets to zero
            r.period     <= `DIMW_PERIOD_RST;
            r.wd_state   <= DIMW_WD_IDLE;
            r.pre        <= 16'h0000;
            r.ms         <= 16'h0000;
            r.wd_expired <= 1'b0;
            r.loop_irq   <= '0;
            r.lim_irq    <= '0;
            r.ref_irq    <= '0;
            r.wdog_irq   <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hrdata       = r.hrdata;
    assign hreadyout    = r.hreadyout;
    assign hresp        = r.hresp;
    assign loop_irq     = r.loop_irq;
    assign lim_irq      = r.lim_irq;
    assign ref_irq      = r.ref_irq;
    assign wdog_irq     = r.wdog_irq;
    // run bit of the one-hot watchdog state
    assign wdog_running = r.wd_state[1];

endmodule

/* File: dv/dimw_host.sv */
`timescale 1ns/1ps
module dimw_host (
    // clock
    input  wire logic        hclk,
    // ahb-lite master side
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    logic hung = 1'b0;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'hA5A5A5A5;
    end
    // one single word transfer; waits are bounded and flag a hang
    task automatic xfer(input logic [9:0] idx, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
        q = hrdata;
        // released data lines show a changed pattern
        hwdata <= ~d;
        if (n >= 64) hung = 1'b1;
    endtask
endmodule

/* File: dv/dimw_top_assertions.sv */
`timescale 1ns/1ps
module dimw_top_chk
    import dimw_pkg::*;
#(
    parameter int unsigned MS_CYCLES = 4
) (
    // clock and reset
    input wire logic          hclk,
    input wire logic          hresetn,
    // bus
    input wire logic          hsel,
    input wire logic [31:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [2:0]    hsize,
    input wire logic [31:0]   hwdata,
    input wire logic          hready,
    input wire logic [31:0]   hrdata,
    input wire logic          hreadyout,
    input wire logic          hresp,
    // events
    input wire dimw_loop_ev_s loop_ev,
    input wire dimw_lim_ev_s  lim_ev,
    input wire dimw_ref_ev_s  ref_ev,
    input wire dimw_loop_ev_s loop_irq,
    input wire dimw_lim_ev_s  lim_irq,
    input wire dimw_ref_ev_s  ref_irq,
    input wire logic          wdog_irq,
    input wire logic          wdog_running
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_taken;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence wd_pulse;
        wdog_irq ##1 !wdog_irq;
    endsequence
    chk_loop_gate: assert property ((loop_irq & ~$past(loop_ev)) == 8'h00)
        else $error("loop irq without event");
    chk_lim_gate: assert property ((lim_irq & ~$past(lim_ev) | 8'hE0 & lim_irq) == 8'h00)
        else $error("limiter irq bad");
    chk_ref_gate: assert property ((ref_irq & ~$past(ref_ev) | 8'h88 & ref_irq) == 8'h00)
        else $error("reference irq bad");
    chk_ready_high: assert property (hreadyout)
        else $error("ready low");
    chk_resp_okay: assert property (!hresp)
        else $error("response not okay");
    chk_rdata_idle: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside data phase");
    chk_rdata_byte: assert property (rd_taken |=> hrdata[31:8] == 24'h0)
        else $error("read upper bits set");
    chk_wdog_pulse: assert property (wdog_irq |-> wd_pulse)
        else $error("expiry not a pulse");
    chk_wdog_gate: assert property (wdog_irq |-> $past(wdog_running))
        else $error("expiry while idle");
endmodule
bind dimw_top dimw_top_chk #(.MS_CYCLES(MS_CYCLES)) dimw_top_chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .loop_ev(loop_ev), .lim_ev(lim_ev),
    .ref_ev(ref_ev), .loop_irq(loop_irq), .lim_irq(lim_irq), .ref_irq(ref_irq),
    .wdog_irq(wdog_irq), .wdog_running(wdog_running));

/* File: dv/dimw_top_tb.sv */
`timescale 1ns/1ps
`include "dimw_cfg.svh"
module dimw_top_tb
    import dimw_pkg::*;
;
    localparam int MS = 4;
    logic          hclk = 1'b0;
    logic          hresetn = 1'b0;
    logic          hsel, hwrite, hreadyout, hresp, wdog_irq, wdog_running;
    logic [31:0]   haddr, hwdata, hrdata, q;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    logic [7:0]    b;
    dimw_loop_ev_s loop_ev = 8'h00, loop_irq;
    dimw_lim_ev_s  lim_ev = 8'h00, lim_irq;
    dimw_ref_ev_s  ref_ev = 8'h00, ref_irq;
    logic [9:0]    idx_t [7] = '{10'h20B, 10'h20C, 10'h20D, 10'h20E, 10'h20F, 10'h210, 10'h211};
    logic [7:0]    exp_t [7] = '{8'h04, 8'hFF, 8'h1F, 8'h77, 8'h00, 8'hFF, 8'hFF};
    int            error_cnt = 0;
    int            num_checks = 0;
    int            t1, t2;
    always #10 hclk = ~hclk;
    dimw_top #(.MS_CYCLES(MS)) dimw_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .loop_ev(loop_ev), .lim_ev(lim_ev),
        .ref_ev(ref_ev), .loop_irq(loop_irq), .lim_irq(lim_irq), .ref_irq(ref_irq),
        .wdog_irq(wdog_irq), .wdog_running(wdog_running));
    dimw_host dimw_host_i (
        .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task wr(input logic [9:0] i, input logic [31:0] d);
        dimw_host_i.xfer(i, 1'b1, d, q);
        if (dimw_host_i.hung) begin error_cnt++; tally_and_finish; end
    endtask
    task rd(input logic [9:0] i, input logic [31:0] e);
        dimw_host_i.xfer(i, 1'b0, 32'h0, q);
        if (dimw_host_i.hung) begin error_cnt++; tally_and_finish; end
        chk(q, e);
    endtask
    // pulse every event for one cycle and compare the masked result
    task ev_chk(input logic [7:0] lm, input logic [7:0] fm, input logic [7:0] rm);
        @(posedge hclk);
        loop_ev <= 8'hFF; lim_ev <= 8'hFF; ref_ev <= 8'hFF;
        @(posedge hclk);
        loop_ev <= 8'h00; lim_ev <= 8'h00; ref_ev <= 8'h00;
        #1 chk({8'h0, loop_irq, lim_irq, ref_irq}, {8'h0, lm, fm, rm});
        @(posedge hclk);
        #1 chk({8'h0, loop_irq, lim_irq, ref_irq}, 32'h0);
    endtask
    task wait_irq(output int n);
        n = 0;
        do begin @(posedge hclk); #1 n++; end while (wdog_irq !== 1'b1 && n < 400);
        if (n >= 400) begin error_cnt++; tally_and_finish; end
    endtask
    task quiet(output int n);
        n = 0;
        repeat (40) begin @(posedge hclk); #1 if (wdog_irq !== 1'b0) n++; end
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(idx_t[i], 32'h0);
        rd(`DIMW_IDX_STATUS, 32'h0);
        for (int i = 0; i < 7; i++) wr(idx_t[i], 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++) rd(idx_t[i], {24'h0, exp_t[i]});
        wr(10'h300, 32'hFF);
        rd(10'h300, 32'h0);
        wr(`DIMW_IDX_PERIOD_LO, 32'h0);
        wr(`DIMW_IDX_PERIOD_HI, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            wr(`DIMW_IDX_LOOP_MASK, {24'h0, b});
            wr(`DIMW_IDX_LIM_MASK, {24'h0, b});
            wr(`DIMW_IDX_REF_MASK, {24'h0, b});
            ev_chk(b, b & 8'h1F, b & 8'h77);
        end
        $display("test event gating done");
        wr(`DIMW_IDX_WDOG_MASK, 32'h4);
        wr(`DIMW_IDX_PERIOD_LO, 32'h3);
        wait_irq(t1);
        wait_irq(t1);
        chk(t1, 3 * MS);
        chk({31'h0, wdog_running}, 32'h1);
        rd(`DIMW_IDX_STATUS, 32'h3);
        wr(`DIMW_IDX_STATUS, 32'h2);
        rd(`DIMW_IDX_STATUS, 32'h1);
        wait_irq(t1);
        repeat (6) @(posedge hclk);
        wr(`DIMW_IDX_PERIOD_LO, 32'h3);
        wait_irq(t1);
        chk(t1, 3 * MS);
        repeat (2) @(posedge hclk);
        wr(`DIMW_IDX_PERIOD_LO, 32'h3);
        wait_irq(t2);
        chk(t2, 3 * MS);
        wr(`DIMW_IDX_WDOG_MASK, 32'h0);
        quiet(t1);
        chk(t1, 0);
        wr(`DIMW_IDX_WDOG_MASK, 32'h4);
        wr(`DIMW_IDX_PERIOD_LO, 32'h0);
        quiet(t1);
        chk(t1, 0);
        chk({31'h0, wdog_running}, 32'h0);
        $display("test watchdog done");
        tally_and_finish;
    end
endmodule
